// ---- ccmd_marker.sv ----
// cell congestion marker/discard stage with policing, tagging and shaping
// assumes 13-word cells (header first); congestion levels arrive asynchronously;
// software reaches the registers over APB with zero wait states
//
// Chosen here: the placing of the registers and the APB slave port.
`default_nettype none

module ccmd_marker
   import ccmd_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   // congestion levels
   input  wire logic              congested_i,
   input  wire logic              impending_i,
   // upstream cell stream
   input  wire logic              in_valid_i,
   output logic                   in_ready_o,
   input  wire logic [DATA_W-1:0] in_data_i,
   input  wire logic              in_noncomp_i,
   // downstream cell stream
   output logic                   out_valid_o,
   input  wire logic              out_ready_i,
   output logic [DATA_W-1:0]      out_data_o,
   output logic                   out_sop_o,
   // apb slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [7:0]        paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic [31:0]            prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o
);

   // configuration and counters
   logic [CTL_W-1:0] ctrl;
   logic [BKT_W-1:0] rate;
   logic [BKT_W-1:0] limit;
   logic [BKT_W-1:0] oam_xtra;
   logic [BKT_W-1:0] oam_lim;
   logic [7:0]       gap;
   logic [31:0]      cnt_mark;
   logic [31:0]      cnt_drop;
   logic [31:0]      cnt_tag;

   // congestion synchronisers
   logic [1:0]  cong_meta;
   logic        cong_s;
   logic        imp_s;

   ccmd_state_t state;
   ccmd_state_t next_state;
   logic [3:0]  beat;
   logic [7:0]  gap_cnt;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cong_meta <= 2'h0;
         cong_s    <= 1'b0;
         imp_s     <= 1'b0;
      end else begin
         cong_meta <= {congested_i, impending_i};
         cong_s    <= cong_meta[1];
         imp_s     <= cong_meta[0];
      end
   end

   // stream control
   logic       buf_in_ready;
   logic       buf_out_valid;
   logic       buf_out_ready;
   ccmd_beat_t buf_out_beat;
   logic       pol_conform;

   wire in_fire  = in_valid_i & in_ready_o;
   wire hdr_fire = in_fire & (state == ST_HDR);
   wire last_in  = in_fire & (beat == LAST_BEAT);

   // header decision, congestion levels taken at this point only
   wire [DATA_W-1:0] hdr      = in_data_i;
   wire              clp      = hdr[CLP_BIT];
   wire              hdr_oam  = ccmd_is_oam(hdr);
   wire              nonconf  = ctrl[CTL_POLICE_EN] & ~pol_conform;
   wire              tag_it   = nonconf & ctrl[CTL_TAG_EN] & ~clp;
   wire              pol_drop = nonconf & ~tag_it;
   wire              eff_clp  = clp | tag_it;
   wire              sel_drop = cong_s & ((ctrl[CTL_DROP_CLP] & eff_clp)
                                        | (ctrl[CTL_DROP_NC] & in_noncomp_i));
   wire              drop_hdr = pol_drop | sel_drop;
   wire              mark_it  = (cong_s | imp_s) & ctrl[CTL_MARK_EN]
                                & ~hdr[PTI_HI];
   wire [DATA_W-1:0] new_hdr  = hdr | ({{(DATA_W-1){1'b0}}, tag_it} << CLP_BIT)
                                | ({{(DATA_W-1){1'b0}}, mark_it} << EFCI_BIT);

   wire        fwd_valid = in_valid_i & (state != ST_DROP) & ~(state == ST_HDR & drop_hdr);
   ccmd_beat_t fwd_beat;
   assign fwd_beat.sop  = (state == ST_HDR);
   assign fwd_beat.data = (state == ST_HDR) ? new_hdr : in_data_i;

   // a dropped cell is swallowed without waiting on the buffer
   assign in_ready_o = (state == ST_DROP) | (state == ST_HDR & drop_hdr) | buf_in_ready;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_HDR:  if (hdr_fire) next_state = drop_hdr ? ST_DROP : ST_PASS;
         ST_PASS: if (last_in) next_state = ST_HDR;
         ST_DROP: if (last_in) next_state = ST_HDR;
         default: next_state = ST_HDR;
      endcase
   end

   // shaping spaces headers; one queue keeps order
   wire hold_hdr  = ctrl[CTL_SHAPE_EN] & buf_out_beat.sop & (gap_cnt != 8'h00);
   wire out_fire  = out_valid_o & out_ready_i;
   assign buf_out_ready = out_ready_i & ~hold_hdr;
   assign out_valid_o   = buf_out_valid & ~hold_hdr;
   assign out_data_o    = buf_out_beat.data;
   assign out_sop_o     = buf_out_beat.sop;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state   <= ST_HDR;
         beat    <= 4'h0;
         gap_cnt <= 8'h00;
      end else begin
         state   <= next_state;
         beat    <= last_in ? 4'h0 : beat + {3'h0, in_fire};
         gap_cnt <= (out_fire & out_sop_o) ? gap :
                    gap_cnt - {7'h0, (gap_cnt != 8'h00)};
      end
   end

   ccmd_buf2 u_buf (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (fwd_valid),
      .in_ready_o  (buf_in_ready),
      .in_beat_i   (fwd_beat),
      .out_valid_o (buf_out_valid),
      .out_ready_i (buf_out_ready),
      .out_beat_o  (buf_out_beat)
   );

   ccmd_policer u_pol (
      .clk_i      (clk_i),
      .rst_b_i    (rst_b_i),
      .check_i    (hdr_fire & ctrl[CTL_POLICE_EN]),
      .is_oam_i   (hdr_oam),
      .conform_o  (pol_conform),
      .joint_i    (ctrl[CTL_OAM_JOINT]),
      .inc_i      (rate),
      .limit_i    (limit),
      .oam_xtra_i (oam_xtra),
      .oam_lim_i  (oam_lim)
   );

   // apb register file, zero wait states
   wire setup    = psel_i & ~penable_i;
   wire wr_acc   = psel_i & penable_i & pwrite_i;
   wire hit_ctrl = (paddr_i == OFS_CTRL);
   wire hit_rate = (paddr_i == OFS_RATE);
   wire hit_lim  = (paddr_i == OFS_LIMIT);
   wire hit_ox   = (paddr_i == OFS_OAM_XTRA);
   wire hit_ol   = (paddr_i == OFS_OAM_LIM);
   wire hit_st   = (paddr_i == OFS_STATUS);
   wire hit_cm   = (paddr_i == OFS_CNT_MARK);
   wire hit_cd   = (paddr_i == OFS_CNT_DROP);
   wire hit_ct   = (paddr_i == OFS_CNT_TAG);
   wire hit_gap  = (paddr_i == OFS_GAP);
   wire mapped   = hit_ctrl | hit_rate | hit_lim | hit_ox | hit_ol | hit_st
                   | hit_cm | hit_cd | hit_ct | hit_gap;
   wire [31:0] rd_mux =
      hit_ctrl ? {25'h0, ctrl} :
      hit_rate ? {16'h0, rate} :
      hit_lim  ? {16'h0, limit} :
      hit_ox   ? {16'h0, oam_xtra} :
      hit_ol   ? {16'h0, oam_lim} :
      hit_st   ? {28'h0, state, imp_s, cong_s} :
      hit_cm   ? cnt_mark :
      hit_cd   ? cnt_drop :
      hit_ct   ? cnt_tag :
      hit_gap  ? {24'h0, gap} : 32'h0000_0000;

   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~mapped;

   // counters: any write clears; a count in the same cycle wins
   wire ev_mark = hdr_fire & ~drop_hdr & mark_it;
   wire ev_drop = hdr_fire & drop_hdr;
   wire ev_tag  = hdr_fire & ~drop_hdr & tag_it;

   function automatic logic [31:0] cnt_next(input logic [31:0] c, input logic clr,
                                            input logic ev);
      return (clr ? 32'h0000_0000 : c) + {31'h0, ev};
   endfunction

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl     <= CTRL_RST;
         rate     <= RATE_RST;
         limit    <= LIMIT_RST;
         oam_xtra <= OAM_XTRA_RST;
         oam_lim  <= OAM_LIM_RST;
         gap      <= GAP_RST;
         prdata_o <= 32'h0000_0000;
         cnt_mark <= 32'h0000_0000;
         cnt_drop <= 32'h0000_0000;
         cnt_tag  <= 32'h0000_0000;
      end else begin
         if (wr_acc & hit_ctrl) ctrl <= pwdata_i[CTL_W-1:0];
         if (wr_acc & hit_rate) rate <= pwdata_i[BKT_W-1:0];
         if (wr_acc & hit_lim) limit <= pwdata_i[BKT_W-1:0];
         if (wr_acc & hit_ox) oam_xtra <= pwdata_i[BKT_W-1:0];
         if (wr_acc & hit_ol) oam_lim <= pwdata_i[BKT_W-1:0];
         if (wr_acc & hit_gap) gap <= pwdata_i[7:0];
         if (setup) prdata_o <= rd_mux;
         cnt_mark <= cnt_next(cnt_mark, wr_acc & hit_cm, ev_mark);
         cnt_drop <= cnt_next(cnt_drop, wr_acc & hit_cd, ev_drop);
         cnt_tag  <= cnt_next(cnt_tag, wr_acc & hit_ct, ev_tag);
      end
   end

   // checks
   a_efci_kept: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hdr_fire && !cong_s && !imp_s |-> fwd_beat.data[EFCI_BIT] == hdr[EFCI_BIT])
      else $error("forward indication changed while uncongested");

   a_efci_marked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hdr_fire && cong_s && ctrl[CTL_MARK_EN] && !hdr[PTI_HI] && !drop_hdr
      |-> fwd_valid && fwd_beat.data[EFCI_BIT])
      else $error("congested user cell not marked");

   a_efci_impend: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hdr_fire && imp_s && ctrl[CTL_MARK_EN] && !hdr[PTI_HI] && !drop_hdr
      |-> fwd_valid && fwd_beat.data[EFCI_BIT])
      else $error("impending user cell not marked");

   a_tag_clp0_only: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hdr_fire && !drop_hdr && !mark_it |-> (fwd_beat.data ^ hdr) == (tag_it ? 32'h1 : 32'h0)
      && (!tag_it || !clp))
      else $error("tagging touched more than a clear priority bit");

   a_clp1_dropped: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hdr_fire && cong_s && ctrl[CTL_DROP_CLP] && clp |=> state == ST_DROP)
      else $error("low-priority cell kept under congestion");

   a_nc_dropped: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hdr_fire && cong_s && ctrl[CTL_DROP_NC] && in_noncomp_i |=> state == ST_DROP)
      else $error("non-compliant cell kept under congestion");

   a_uncong_nodrop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hdr_fire && !cong_s && !ctrl[CTL_POLICE_EN] |=> state == ST_PASS)
      else $error("cell dropped without congestion or policing");

   a_impend_kept: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      hdr_fire && !cong_s && !pol_drop |=> state == ST_PASS)
      else $error("cell dropped without congestion");

   a_drop_whole: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      state == ST_DROP && !last_in |=> state == ST_DROP)
      else $error("dropped cell cut short");

   a_cong_sampled: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ##2 cong_s == $past(congested_i, 2))
      else $error("congestion level not taken through two stages");

   a_imp_sampled: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ##2 imp_s == $past(impending_i, 2))
      else $error("impending level not taken through two stages");

   a_drop_silent: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      state == ST_DROP |-> !fwd_valid && in_ready_o)
      else $error("dropped cell reached the queue");

   a_payload_intact: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      state == ST_PASS && in_valid_i |-> fwd_valid && !fwd_beat.sop
      && fwd_beat.data == in_data_i)
      else $error("payload word altered or not queued");

   a_hdr_spacing: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      out_fire && out_sop_o |=> !(out_fire && out_sop_o))
      else $error("two headers left back to back");

   a_gap_held: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      out_fire && out_sop_o && ctrl[CTL_SHAPE_EN] && gap >= 8'h02
      |=> !(out_fire && out_sop_o) [*2])
      else $error("header released before spacing elapsed");

   c_marked:  cover property (@(posedge clk_i) disable iff (!rst_b_i) ev_mark);
   c_tagged:  cover property (@(posedge clk_i) disable iff (!rst_b_i) ev_tag);
   c_dropped: cover property (@(posedge clk_i) disable iff (!rst_b_i) ev_drop ##[1:20] last_in);
   c_shaped:  cover property (@(posedge clk_i) disable iff (!rst_b_i) hold_hdr && buf_out_valid);

endmodule // ccmd_marker

`default_nettype wire

// ---- ccmd_pkg.sv ----
// cell congestion marker/discard: shared constants, register map and types
// assumes a 32-bit cell word stream, header word first, then 12 payload words
`default_nettype none

package ccmd_pkg;

   // cell framing
   localparam int unsigned DATA_W     = 32;
   localparam logic [3:0]  CELL_BEATS = 4'hd;
   localparam logic [3:0]  LAST_BEAT  = 4'hc;

   // header field positions
   localparam int unsigned CLP_BIT  = 0;
   localparam int unsigned EFCI_BIT = 2;
   localparam int unsigned PTI_HI   = 3;
   localparam int unsigned PTI_LO   = 1;
   localparam logic [2:0]  PTI_OAM_SEG = 3'h4;
   localparam logic [2:0]  PTI_OAM_E2E = 3'h5;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_RATE     = 8'h04;
   localparam logic [7:0] OFS_LIMIT    = 8'h08;
   localparam logic [7:0] OFS_OAM_XTRA = 8'h0c;
   localparam logic [7:0] OFS_OAM_LIM  = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;
   localparam logic [7:0] OFS_CNT_MARK = 8'h18;
   localparam logic [7:0] OFS_CNT_DROP = 8'h1c;
   localparam logic [7:0] OFS_CNT_TAG  = 8'h20;
   localparam logic [7:0] OFS_GAP      = 8'h24;

   // control bit positions
   localparam int unsigned CTL_MARK_EN   = 0;
   localparam int unsigned CTL_DROP_CLP  = 1;
   localparam int unsigned CTL_DROP_NC   = 2;
   localparam int unsigned CTL_POLICE_EN = 3;
   localparam int unsigned CTL_OAM_JOINT = 4;
   localparam int unsigned CTL_TAG_EN    = 5;
   localparam int unsigned CTL_SHAPE_EN  = 6;
   localparam int unsigned CTL_W         = 7;

   // reset values
   localparam logic [6:0]  CTRL_RST     = 7'h01;
   localparam int unsigned BKT_W        = 16;
   localparam logic [15:0] RATE_RST     = 16'h0010;
   localparam logic [15:0] LIMIT_RST    = 16'h0100;
   localparam logic [15:0] OAM_XTRA_RST = 16'h0020;
   localparam logic [15:0] OAM_LIM_RST  = 16'h0040;
   localparam logic [7:0]  GAP_RST      = 8'h00;

   typedef struct packed {
      logic              sop;
      logic [DATA_W-1:0] data;
   } ccmd_beat_t;

   typedef enum logic [1:0] {
      ST_HDR  = 2'b00,
      ST_PASS = 2'b01,
      ST_DROP = 2'b11
   } ccmd_state_t;

   function automatic logic ccmd_is_oam(input logic [DATA_W-1:0] hdr);
      return (hdr[PTI_HI:PTI_LO] == PTI_OAM_SEG) || (hdr[PTI_HI:PTI_LO] == PTI_OAM_E2E);
   endfunction

   function automatic logic [BKT_W-1:0] ccmd_sat_add(input logic [BKT_W-1:0] a,
                                                    input logic [BKT_W-1:0] b);
      logic [BKT_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[BKT_W] ? {BKT_W{1'b1}} : s[BKT_W-1:0];
   endfunction

endpackage

`default_nettype wire

// ---- ccmd_buf2.sv ----
// two-entry buffer for cell beats, valid/ready on both sides
// assumes both sides on clk_i; order of words is kept strictly
`default_nettype none

module ccmd_buf2
   import ccmd_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // fill side
   input  wire logic       in_valid_i,
   output logic            in_ready_o,
   input  wire ccmd_beat_t in_beat_i,
   // drain side
   output logic            out_valid_o,
   input  wire logic       out_ready_i,
   output ccmd_beat_t      out_beat_o
);

   ccmd_beat_t mem [2];
   logic       wr_ptr;
   logic       rd_ptr;
   logic [1:0] count;
   wire        wr_fire = in_valid_i & in_ready_o;
   wire        rd_fire = out_valid_o & out_ready_i;

   assign in_ready_o  = (count != 2'h2);
   assign out_valid_o = (count != 2'h0);
   assign out_beat_o  = mem[rd_ptr];

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         wr_ptr <= wr_ptr ^ wr_fire;
         rd_ptr <= rd_ptr ^ rd_fire;
         count  <= count + {1'b0, wr_fire} - {1'b0, rd_fire};
      end
   end

   // payload storage needs no reset
   always_ff @(posedge clk_i) begin
      if (wr_fire) begin
         mem[wr_ptr] <= in_beat_i;
      end
   end

   a_buf_fifo_order: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_fire && count == 2'h0 |=> out_beat_o == $past(in_beat_i))
      else $error("buffer head is not the oldest word");

endmodule // ccmd_buf2

`default_nettype wire

// ---- ccmd_policer.sv ----
// leaky-bucket conformance check for user and maintenance cells
// assumes check_i pulses once per header; buckets leak one unit per clock
`default_nettype none

module ccmd_policer
   import ccmd_pkg::*;
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   // per-cell check
   input  wire logic             check_i,
   input  wire logic             is_oam_i,
   output logic                  conform_o,
   // configuration
   input  wire logic             joint_i,
   input  wire logic [BKT_W-1:0] inc_i,
   input  wire logic [BKT_W-1:0] limit_i,
   input  wire logic [BKT_W-1:0] oam_xtra_i,
   input  wire logic [BKT_W-1:0] oam_lim_i
);

   logic [BKT_W-1:0] ubkt;
   logic [BKT_W-1:0] obkt;

   wire             use_user  = ~is_oam_i | joint_i;
   // joint policing widens the shared bucket's limit by the maintenance allowance for maintenance cells only
   wire [BKT_W:0]   joint_lim = {1'b0, limit_i} + {1'b0, oam_xtra_i};
   wire [BKT_W:0]   lim       = !is_oam_i ? {1'b0, limit_i} :
                                (joint_i ? joint_lim : {1'b0, oam_lim_i});
   wire [BKT_W-1:0] level     = use_user ? ubkt : obkt;
   wire [BKT_W:0]   want      = {1'b0, level} + {1'b0, inc_i};
   wire [BKT_W-1:0] u_leak    = ubkt - {{(BKT_W-1){1'b0}}, (ubkt != '0)};
   wire [BKT_W-1:0] o_leak    = obkt - {{(BKT_W-1){1'b0}}, (obkt != '0)};
   wire             charge    = check_i & conform_o;
   wire [BKT_W-1:0] next_ubkt = ccmd_sat_add(u_leak, (charge & use_user) ? inc_i : '0);
   wire [BKT_W-1:0] next_obkt = ccmd_sat_add(o_leak, (charge & ~use_user) ? inc_i : '0);

   assign conform_o = (want <= lim);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ubkt <= '0;
         obkt <= '0;
      end else begin
         ubkt <= next_ubkt;
         obkt <= next_obkt;
      end
   end

   a_oam_joint_charge: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      check_i && is_oam_i && joint_i && conform_o
      |=> ubkt == ccmd_sat_add($past(u_leak), $past(inc_i)))
      else $error("joint maintenance cell not charged to user bucket");

   a_oam_sep_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      check_i && is_oam_i && !joint_i |=> ubkt == $past(u_leak))
      else $error("separate maintenance cell touched user bucket");

   a_joint_widened: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      check_i && is_oam_i && joint_i && want <= joint_lim |-> conform_o)
      else $error("joint limit not widened by allowance");

endmodule // ccmd_policer

`default_nettype wire

// ---- ccmd_sink_model.sv ----
// far-side model: downstream switch port taking cell words from the marker
// assumes one clock; records every word taken and stalls when the bench asks
`default_nettype none

module ccmd_sink_model
   import ccmd_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   // control from bench
   input  wire logic              stall_i,
   // cell stream from the marker
   input  wire logic              out_valid_i,
   output logic                   out_ready_o,
   input  wire logic [DATA_W-1:0] out_data_i,
   input  wire logic              out_sop_i
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] phase;
   ccmd_beat_t got[$];

   // one word in three while stalling, so the two-entry buffer fills and refuses
   assign out_ready_o = !stall_i || (phase == 2'h0);

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase <= 2'h0;
      end else begin
         phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
         if (out_valid_i && out_ready_o) begin
            got.push_back('{sop: out_sop_i, data: out_data_i});
         end
      end
   end
endmodule // ccmd_sink_model

`default_nettype wire

// ---- ccmd_marker_tb_top.sv ----
// testbench for the cell congestion marker: apb master, cell source, checks
// assumes ccmd_pkg and ccmd_sink_model compiled first; one 100 MHz clock
`default_nettype none

module ccmd_marker_tb_top
   import ccmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i, rst_b_i, congested_i, impending_i;
   logic        in_valid_i, in_ready_o, in_noncomp_i, out_ready_i;
   logic        out_valid_o, out_sop_o, psel_i, penable_i, pwrite_i;
   logic        pready_o, pslverr_o, stall;
   logic [7:0]  paddr_i;
   logic [31:0] in_data_i, out_data_o, pwdata_i, prdata_o, d;
   logic        e;
   int          err_total = 0;
   int          num_checks = 0;
   ccmd_beat_t  exp_q[$];

   localparam logic [31:0] C_MARK = 32'h1 << CTL_MARK_EN;
   localparam logic [31:0] C_DCLP = 32'h1 << CTL_DROP_CLP;
   localparam logic [31:0] C_DNC  = 32'h1 << CTL_DROP_NC;
   localparam logic [31:0] C_POL  = 32'h1 << CTL_POLICE_EN;
   localparam logic [31:0] C_JNT  = 32'h1 << CTL_OAM_JOINT;
   localparam logic [31:0] C_TAG  = 32'h1 << CTL_TAG_EN;
   localparam logic [31:0] C_SHP  = 32'h1 << CTL_SHAPE_EN;
   logic [7:0]  ofs [6] = '{OFS_CTRL, OFS_RATE, OFS_LIMIT, OFS_OAM_XTRA, OFS_OAM_LIM, OFS_GAP};
   logic [31:0] rv  [6] = '{32'(CTRL_RST), 32'(RATE_RST), 32'(LIMIT_RST), 32'(OAM_XTRA_RST),
                            32'(OAM_LIM_RST), 32'(GAP_RST)};

   ccmd_marker ccmd_marker_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .congested_i(congested_i),
      .impending_i(impending_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
      .in_data_i(in_data_i), .in_noncomp_i(in_noncomp_i), .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i), .out_data_o(out_data_o), .out_sop_o(out_sop_o),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

   ccmd_sink_model ccmd_sink_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .stall_i(stall),
      .out_valid_i(out_valid_o), .out_ready_o(out_ready_i), .out_data_i(out_data_o),
      .out_sop_i(out_sop_o));

   task automatic wrap_up();
      if (err_total == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [32:0] want, input logic [32:0] seen);
      num_checks++;
      if (seen !== want) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask

   // entered right after a rising edge; returns one idle edge after the access edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      d         = prdata_o;
      e         = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(a, 1'b1, v);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
      apb(a, 1'b0, 32'h0);
      chk($sformatf("reg %h", a), {1'b0, want}, {1'b0, d});
   endtask

   // payload word k carries the header's upper bits and k, so order shows
   task automatic send_cell(input logic [31:0] hdr, input logic nc, input logic keep,
                            input logic [31:0] want_hdr);
      logic rdy;
      for (int k = 0; k < int'(CELL_BEATS); k++) begin
         in_valid_i   <= 1'b1;
         in_data_i    <= (k == 0) ? hdr : {hdr[31:4], 4'(k)};
         in_noncomp_i <= nc;
         if (keep) exp_q.push_back('{sop: (k == 0), data: (k == 0) ? want_hdr : {hdr[31:4], 4'(k)}});
         do begin
            @(negedge clk_i);
            rdy = in_ready_o;
            @(posedge clk_i);
         end while (rdy !== 1'b1);
      end
      in_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic flush(input string what);
      int n;
      n = 0;
      while (ccmd_sink_model_i.got.size() < exp_q.size() && n < 600) begin
         @(posedge clk_i);
         n++;
      end
      repeat (30) @(posedge clk_i);
      chk({what, " words"}, 33'(exp_q.size()), 33'(ccmd_sink_model_i.got.size()));
      foreach (exp_q[j]) begin
         if (j < ccmd_sink_model_i.got.size()) chk(what, exp_q[j], ccmd_sink_model_i.got[j]);
      end
      exp_q.delete();
      ccmd_sink_model_i.got.delete();
   endtask

   task automatic set_cong(input logic c, input logic i);
      congested_i <= c;
      impending_i <= i;
      repeat (4) @(posedge clk_i);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // whole run is under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      wrap_up();
   end

   initial begin
      {rst_b_i, congested_i, impending_i, in_valid_i, in_noncomp_i, stall} = 6'h0;
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, in_data_i} = '0;
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      foreach (ofs[j]) rd_chk(ofs[j], rv[j]);
      apb(8'h28, 1'b0, 32'h0);
      chk("unmapped err", 33'h1, {32'h0, e});
      chk("unmapped data", 33'h0, {1'b0, d});
      // drops armed but idle element: nothing may change
      wr(OFS_CTRL, C_MARK | C_DCLP | C_DNC);
      stall <= 1'b1;
      send_cell(32'h00000010, 1'b0, 1'b1, 32'h00000010);
      send_cell(32'h00000024, 1'b0, 1'b1, 32'h00000024);
      send_cell(32'h00000031, 1'b1, 1'b1, 32'h00000031);
      flush("idle");
      set_cong(1'b0, 1'b1);
      apb(OFS_STATUS, 1'b0, 32'h0);
      chk("status", 33'h2, {31'h0, d[1:0]});
      send_cell(32'h00000040, 1'b0, 1'b1, 32'h00000044);
      send_cell(32'h00000051, 1'b0, 1'b1, 32'h00000055);
      flush("impending");
      set_cong(1'b1, 1'b0);
      wr(OFS_CNT_DROP, 32'h0);
      send_cell(32'h00000071, 1'b0, 1'b0, 32'h0);
      send_cell(32'h00000080, 1'b0, 1'b1, 32'h00000084);
      wr(OFS_CTRL, C_MARK | C_DNC);
      send_cell(32'h00000090, 1'b1, 1'b0, 32'h0);
      send_cell(32'h000000a1, 1'b0, 1'b1, 32'h000000a5);
      flush("congested");
      rd_chk(OFS_CNT_DROP, 32'h2);
      rd_chk(OFS_CNT_MARK, 32'h4);
      set_cong(1'b0, 1'b0);
      // over-rate cells: clear one tagged, already-set one dropped
      stall <= 1'b0;
      wr(OFS_RATE, 32'h80);
      wr(OFS_LIMIT, 32'h80);
      wr(OFS_CTRL, C_POL | C_TAG);
      repeat (300) @(posedge clk_i);
      send_cell(32'h000000b0, 1'b0, 1'b1, 32'h000000b0);
      send_cell(32'h000000c0, 1'b0, 1'b1, 32'h000000c1);
      send_cell(32'h000000d1, 1'b0, 1'b0, 32'h0);
      flush("tagging");
      rd_chk(OFS_CNT_TAG, 32'h1);
      // maintenance cells on their own bucket
      wr(OFS_OAM_LIM, 32'h100);
      wr(OFS_CTRL, C_POL);
      repeat (300) @(posedge clk_i);
      send_cell(32'h000000e0, 1'b0, 1'b1, 32'h000000e0);
      send_cell(32'h000000f8, 1'b0, 1'b1, 32'h000000f8);
      send_cell(32'h00000100, 1'b0, 1'b0, 32'h0);
      flush("separate");
      // joint: only the widened limit lets the maintenance cell through
      wr(OFS_OAM_LIM, 32'h40);
      wr(OFS_OAM_XTRA, 32'h80);
      wr(OFS_CTRL, C_POL | C_JNT);
      repeat (300) @(posedge clk_i);
      send_cell(32'h00000110, 1'b0, 1'b1, 32'h00000110);
      send_cell(32'h00000128, 1'b0, 1'b1, 32'h00000128);
      send_cell(32'h00000130, 1'b0, 1'b0, 32'h0);
      flush("joint");
      // shaping with a stalling receiver must keep word order
      wr(OFS_GAP, 32'h10);
      wr(OFS_CTRL, C_MARK | C_SHP);
      stall <= 1'b1;
      for (int c = 0; c < 3; c++) begin
         send_cell(32'h00000200 + 32'(c) * 32'h10, 1'b0, 1'b1, 32'h00000200 + 32'(c) * 32'h10);
      end
      flush("shaping");
      wrap_up();
   end
endmodule // ccmd_marker_tb_top

`default_nettype wire
